// ### fls_pkg.sv
// shared constants for the floating logic support block
`default_nettype none
package fls_pkg;
   // clock and link rates
   localparam int CLK_HZ = 20_000_000;
   localparam int UART_BAUD = 187_500;
   localparam int UART_DATA_BITS = 9;
   localparam int UART_BIT_CYC = (CLK_HZ + UART_BAUD / 2) / UART_BAUD;
   localparam int CFG_BIT_RATE = 1_500_000;
   localparam int CFG_BIT_CYC = CLK_HZ / CFG_BIT_RATE;
   localparam int CFG_BITS = 16;
   // mains window
   localparam int LINE_LOW_HZ = 55;
   localparam int LINE_HIGH_HZ = 66;
   localparam int LINE_MIN_PERIOD_CYC = (CLK_HZ + LINE_HIGH_HZ - 1) / LINE_HIGH_HZ;
   localparam int LINE_MAX_PERIOD_CYC = CLK_HZ / LINE_LOW_HZ;
   // offset trim modulator
   localparam int PWM_HZ = 23_000;
   localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
   localparam int PWM_W = 10;
   // real-time clock
   localparam int RTC_TICK_CYC = CLK_HZ;
   localparam int SQW_HZ = 1024;
   localparam int SQW_HALF_CYC = CLK_HZ / (2 * SQW_HZ);
   localparam logic [6:0] RTC_YEAR_LAST = 7'h63;
   // memory map
   localparam logic [15:0] MAP_PAGE_BASE = 16'h8000;
   localparam logic [15:0] MAP_REG_FIRST = 16'h1FC0;
   localparam logic [15:0] MAP_REG_LAST = 16'h1FDF;
   localparam logic [15:0] MAP_ROM_FIRST = 16'h2000;
   localparam logic [15:0] MAP_ROM_LAST = 16'h5FFF;
   localparam int PAGE_W = 5;
   // synchroniser layout: 13 control bits over the 16-bit bus
   localparam int SYNC_W = 29;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 29'h07A0_0000;
   // uart receiver states, gray along the frame
   typedef enum logic [1:0] {
      FLS_RX_IDLE = 2'b00,
      FLS_RX_START = 2'b01,
      FLS_RX_DATA = 2'b11,
      FLS_RX_STOP = 2'b10
   } fls_rx_state_t;
endpackage : fls_pkg
`default_nettype wire

// ### fls_uart.sv
// nine-bit uart, one start bit, one stop bit
`timescale 1ns/1ps
`default_nettype none
module fls_uart #(
   parameter int CYC_PER_BIT = fls_pkg::UART_BIT_CYC,
   parameter int DATA_BITS = fls_pkg::UART_DATA_BITS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic tx_start,
   input wire logic [DATA_BITS-1:0] tx_data,
   output logic tx_line,
   output logic tx_busy,
   input wire logic rx_line,
   output logic [DATA_BITS-1:0] rx_data,
   output logic rx_valid,
   output logic rx_frame_err
);
   localparam int CW = $clog2(CYC_PER_BIT + 1);
   localparam logic [CW-1:0] LAST = CW'(CYC_PER_BIT - 1);
   localparam logic [CW-1:0] HALF = CW'(CYC_PER_BIT / 2);
   localparam logic [3:0] TX_BITS = 4'(DATA_BITS + 1);
   localparam logic [3:0] RX_LAST = 4'(DATA_BITS - 1);

   initial begin
      if (CYC_PER_BIT < 4 || DATA_BITS < 1 || DATA_BITS > 14) $error("fls_uart: bad parameters");
   end

   logic [DATA_BITS:0] tx_shift;
   logic [3:0] tx_left;
   logic [CW-1:0] tx_cnt;
   fls_pkg::fls_rx_state_t rx_state;
   logic [CW-1:0] rx_cnt;
   logic [3:0] rx_bit;

   // idle high, start low, lsb first, stop high
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_line <= 1'b1;
         tx_busy <= 1'b0;
         tx_shift <= '0;
         tx_left <= 4'h0;
         tx_cnt <= '0;
      end else if (!tx_busy) begin
         if (tx_start) begin
            tx_shift <= {1'b1, tx_data};
            tx_left <= TX_BITS;
            tx_line <= 1'b0;
            tx_busy <= 1'b1;
            tx_cnt <= '0;
         end
      end else if (tx_cnt != LAST) begin
         tx_cnt <= tx_cnt + 1'b1;
      end else begin
         tx_cnt <= '0;
         if (tx_left == 4'h0) begin
            tx_busy <= 1'b0;
         end else begin
            tx_line <= tx_shift[0];
            tx_shift <= tx_shift >> 1;
            tx_left <= tx_left - 4'h1;
         end
      end
   end

   // sample each bit at its middle; a glitch shorter than half a bit is dropped
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_state <= fls_pkg::FLS_RX_IDLE;
         rx_cnt <= '0;
         rx_bit <= 4'h0;
         rx_data <= '0;
         rx_valid <= 1'b0;
         rx_frame_err <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         rx_frame_err <= 1'b0;
         rx_cnt <= rx_cnt + 1'b1;
         unique case (rx_state)
            fls_pkg::FLS_RX_IDLE: begin
               rx_cnt <= '0;
               if (!rx_line) rx_state <= fls_pkg::FLS_RX_START;
            end
            fls_pkg::FLS_RX_START: begin
               if (rx_cnt == HALF) begin
                  rx_cnt <= '0;
                  rx_bit <= 4'h0;
                  rx_state <= rx_line ? fls_pkg::FLS_RX_IDLE : fls_pkg::FLS_RX_DATA;
               end
            end
            fls_pkg::FLS_RX_DATA: begin
               if (rx_cnt == LAST) begin
                  rx_cnt <= '0;
                  rx_data <= {rx_line, rx_data[DATA_BITS-1:1]};
                  rx_bit <= rx_bit + 4'h1;
                  if (rx_bit == RX_LAST) rx_state <= fls_pkg::FLS_RX_STOP;
               end
            end
            fls_pkg::FLS_RX_STOP: begin
               if (rx_cnt == LAST) begin
                  rx_valid <= rx_line;
                  rx_frame_err <= !rx_line;
                  rx_state <= fls_pkg::FLS_RX_IDLE;
               end
            end
         endcase
      end
   end
endmodule : fls_uart
`default_nettype wire

// ### fls_top.sv
// floating logic support: memory interface, serial ports, clock, counter
`timescale 1ns/1ps
`default_nettype none
// Function
// - controller link: 11-bit frames, 187.5 kbit/s
// - frame is start, nine data, stop
// - mains 55 to 66 Hz selects 60 Hz
// - any other mains frequency selects 50 Hz
// - carry pulses extend count to 24 bits
// - latch bus address, drive word address bus
// - data, instruction and mappable memory segments
// - backplane uart, 187.5 kbit/s, nine bits
// - identical nine-bit uart for front panel
// - 1.5 Mbit/s clocked configuration shift port
// - time, date, periodic interrupt, square wave
// - hundred-year calendar with correct leap days
// - converter mode samples and counts comparator
// - frequency mode counts frequency input edges
// - eight-bit counter gives low count bits
// - counter overflow emits carry pulse
// - sync strobe latches the count
// - no memory write without good supply
// - 23 kHz modulator sets offset trim
// - byte write strobes from a0, high enable
// - reads always full word, one strobe
module fls_top #(
   parameter int LINE_MIN_CYC = fls_pkg::LINE_MIN_PERIOD_CYC,
   parameter int LINE_MAX_CYC = fls_pkg::LINE_MAX_PERIOD_CYC,
   parameter int RTC_TICK_CYC = fls_pkg::RTC_TICK_CYC,
   parameter int SQW_HALF_CYC = fls_pkg::SQW_HALF_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [15:0] addr_data_bus,
   input wire logic addr_latch_en,
   input wire logic inst_fetch,
   input wire logic read_n,
   input wire logic write_n,
   input wire logic byte_high_enable_n,
   input wire logic power_loss_warning,
   input wire logic [fls_pkg::PAGE_W-1:0] page_sel,
   input wire logic page_is_ram,
   output logic [19:1] memory_addr_bus,
   output logic rom_select,
   output logic ram_select,
   output logic asic_reg_select,
   output logic mem_read_n,
   output logic write_high_byte_n,
   output logic write_low_byte_n,
   input wire logic bp_tx_start,
   input wire logic [8:0] bp_tx_data,
   output logic backplane_tx,
   output logic bp_tx_busy,
   input wire logic backplane_rx_n,
   output logic [8:0] bp_rx_data,
   output logic bp_rx_valid,
   output logic bp_rx_frame_err,
   input wire logic panel_tx_start,
   input wire logic [8:0] panel_tx_data,
   output logic panel_tx,
   output logic panel_tx_busy,
   input wire logic panel_rx,
   output logic [8:0] panel_rx_data,
   output logic panel_rx_valid,
   output logic panel_rx_frame_err,
   input wire logic cfg_start,
   input wire logic [fls_pkg::CFG_BITS-1:0] cfg_wr_data,
   output logic config_shift_clk,
   output logic config_shift_out,
   input wire logic config_shift_in,
   output logic [fls_pkg::CFG_BITS-1:0] cfg_rd_data,
   output logic cfg_busy,
   output logic cfg_done,
   input wire logic rtc_set,
   input wire logic [5:0] set_second,
   input wire logic [5:0] set_minute,
   input wire logic [4:0] set_hour,
   input wire logic [4:0] set_day,
   input wire logic [3:0] set_month,
   input wire logic [6:0] set_year,
   output logic [5:0] second,
   output logic [5:0] minute,
   output logic [4:0] hour,
   output logic [4:0] day,
   output logic [3:0] month,
   output logic [6:0] year,
   output logic rtc_periodic_irq,
   output logic rtc_square_wave,
   input wire logic freq_mode,
   input wire logic comparator_in,
   input wire logic frequency_in,
   input wire logic count_sync,
   output logic comparator_sampled,
   output logic overflow_carry_pulse,
   output logic [7:0] latched_low_count,
   input wire logic mains_sense,
   output logic select_60hz,
   input wire logic [fls_pkg::PWM_W-1:0] trim_duty,
   output logic offset_trim_voltage
);
   localparam int LW = $clog2(LINE_MAX_CYC + 2);
   localparam int TW = $clog2(RTC_TICK_CYC + 1);
   localparam int SW = $clog2(SQW_HALF_CYC + 1);
   localparam int CFW = $clog2(fls_pkg::CFG_BIT_CYC + 1);

   initial begin
      if (LINE_MIN_CYC < 2 || LINE_MAX_CYC <= LINE_MIN_CYC || RTC_TICK_CYC < 2 || SQW_HALF_CYC < 1)
         $error("fls_top: bad parameters");
   end

   // two-flop synchroniser for every pin from the controller's side
   logic [fls_pkg::SYNC_W-1:0] sync_meta;
   logic [fls_pkg::SYNC_W-1:0] sync_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_meta <= fls_pkg::SYNC_RESET;
         sync_q <= fls_pkg::SYNC_RESET;
      end else begin
         sync_meta <= {addr_latch_en, inst_fetch, read_n, write_n, byte_high_enable_n, power_loss_warning,
                       backplane_rx_n, panel_rx, config_shift_in, comparator_in, frequency_in, count_sync,
                       mains_sense, addr_data_bus};
         sync_q <= sync_meta;
      end
   end
   logic ale_s, fetch_s, rd_n_s, wr_n_s, byte_high_enable_n_s, pwr_s, bprx_n_s, fprx_s, cfgin_s, comp_s, freq_s, sync_s, mains_s;
   logic [15:0] ad_s;
   assign {ale_s, fetch_s, rd_n_s, wr_n_s, byte_high_enable_n_s, pwr_s, bprx_n_s, fprx_s, cfgin_s, comp_s, freq_s, sync_s,
           mains_s, ad_s} = sync_q;

   // edge history of synchronised levels
   logic ale_d, src_d, sync_d, mains_d;
   logic count_src;
   assign count_src = freq_mode ? freq_s : comp_s;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ale_d <= 1'b0;
         src_d <= 1'b0;
         sync_d <= 1'b0;
         mains_d <= 1'b0;
      end else begin
         ale_d <= ale_s;
         src_d <= count_src;
         sync_d <= sync_s;
         mains_d <= mains_s;
      end
   end

   // address latch and segment mapper; decode happens when the latch closes
   logic addr_bit0;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         memory_addr_bus <= '0;
         rom_select <= 1'b0;
         ram_select <= 1'b0;
         asic_reg_select <= 1'b0;
         addr_bit0 <= 1'b0;
      end else if (ale_d && !ale_s) begin
         addr_bit0 <= ad_s[0];
         if (ad_s >= fls_pkg::MAP_PAGE_BASE) begin
            memory_addr_bus <= {page_sel, ad_s[14:1]};
            rom_select <= !page_is_ram;
            ram_select <= page_is_ram;
            asic_reg_select <= 1'b0;
         end else begin
            memory_addr_bus <= {4'h0, ad_s[15:1]};
            if (ad_s >= fls_pkg::MAP_REG_FIRST && ad_s <= fls_pkg::MAP_REG_LAST) begin
               rom_select <= 1'b0;
               ram_select <= 1'b0;
               asic_reg_select <= 1'b1;
            end else if (ad_s >= fls_pkg::MAP_ROM_FIRST && ad_s <= fls_pkg::MAP_ROM_LAST) begin
               rom_select <= 1'b1;
               ram_select <= 1'b0;
               asic_reg_select <= 1'b0;
            end else begin
               rom_select <= fetch_s;
               ram_select <= !fetch_s;
               asic_reg_select <= 1'b0;
            end
         end
      end
   end

   // strobes; a warning from the supply supervisor blocks every write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_read_n <= 1'b1;
         write_high_byte_n <= 1'b1;
         write_low_byte_n <= 1'b1;
      end else begin
         mem_read_n <= rd_n_s;
         write_high_byte_n <= wr_n_s || pwr_s || byte_high_enable_n_s;
         write_low_byte_n <= wr_n_s || pwr_s || addr_bit0;
      end
   end

   // backplane receive pin is inverted, so it idles low
   fls_uart u_bp_uart (
      .clk(clk),
      .reset_n(reset_n),
      .tx_start(bp_tx_start),
      .tx_data(bp_tx_data),
      .tx_line(backplane_tx),
      .tx_busy(bp_tx_busy),
      .rx_line(!bprx_n_s),
      .rx_data(bp_rx_data),
      .rx_valid(bp_rx_valid),
      .rx_frame_err(bp_rx_frame_err)
   );
   fls_uart u_panel_uart (
      .clk(clk),
      .reset_n(reset_n),
      .tx_start(panel_tx_start),
      .tx_data(panel_tx_data),
      .tx_line(panel_tx),
      .tx_busy(panel_tx_busy),
      .rx_line(fprx_s),
      .rx_data(panel_rx_data),
      .rx_valid(panel_rx_valid),
      .rx_frame_err(panel_rx_frame_err)
   );

   // configuration shift port: msb first, out on clock low, sampled at rising edge
   logic [CFW-1:0] cfg_phase;
   logic [4:0] cfg_left;
   logic [fls_pkg::CFG_BITS-1:0] cfg_shift;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_phase <= '0;
         cfg_left <= 5'h00;
         cfg_shift <= '0;
         cfg_rd_data <= '0;
         cfg_busy <= 1'b0;
         cfg_done <= 1'b0;
         config_shift_clk <= 1'b0;
         config_shift_out <= 1'b0;
      end else begin
         cfg_done <= 1'b0;
         if (!cfg_busy) begin
            if (cfg_start) begin
               cfg_busy <= 1'b1;
               cfg_phase <= '0;
               cfg_left <= 5'(fls_pkg::CFG_BITS);
               cfg_shift <= cfg_wr_data;
               config_shift_out <= cfg_wr_data[fls_pkg::CFG_BITS-1];
            end
         end else if (cfg_phase == CFW'(fls_pkg::CFG_BIT_CYC / 2)) begin
            config_shift_clk <= 1'b1;
            cfg_shift <= {cfg_shift[fls_pkg::CFG_BITS-2:0], cfgin_s};
            cfg_phase <= cfg_phase + 1'b1;
         end else if (cfg_phase == CFW'(fls_pkg::CFG_BIT_CYC - 1)) begin
            config_shift_clk <= 1'b0;
            cfg_phase <= '0;
            cfg_left <= cfg_left - 5'h01;
            config_shift_out <= cfg_shift[fls_pkg::CFG_BITS-1];
            if (cfg_left == 5'h01) begin
               cfg_busy <= 1'b0;
               cfg_done <= 1'b1;
               cfg_rd_data <= cfg_shift;
            end
         end else begin
            cfg_phase <= cfg_phase + 1'b1;
         end
      end
   end

   // real-time clock; year 00 is a leap year, right for one century
   function automatic logic [4:0] fls_month_days(input logic [3:0] m, input logic [6:0] y);
      unique case (m)
         4'h2: fls_month_days = (y[1:0] == 2'b00) ? 5'h1D : 5'h1C;
         4'h4, 4'h6, 4'h9, 4'hB: fls_month_days = 5'h1E;
         default: fls_month_days = 5'h1F;
      endcase
   endfunction : fls_month_days

   logic [TW-1:0] tick_cnt;
   logic [SW-1:0] sqw_cnt;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt <= '0;
         rtc_periodic_irq <= 1'b0;
         second <= 6'h00;
         minute <= 6'h00;
         hour <= 5'h00;
         day <= 5'h01;
         month <= 4'h1;
         year <= 7'h00;
      end else begin
         rtc_periodic_irq <= 1'b0;
         if (rtc_set) begin
            tick_cnt <= '0;
            {second, minute, hour, day, month, year} <= {set_second, set_minute, set_hour, set_day, set_month,
                                                         set_year};
         end else if (tick_cnt != TW'(RTC_TICK_CYC - 1)) begin
            tick_cnt <= tick_cnt + 1'b1;
         end else begin
            tick_cnt <= '0;
            rtc_periodic_irq <= 1'b1;
            second <= (second == 6'h3B) ? 6'h00 : second + 6'h01;
            if (second == 6'h3B) begin
               minute <= (minute == 6'h3B) ? 6'h00 : minute + 6'h01;
               if (minute == 6'h3B) begin
                  hour <= (hour == 5'h17) ? 5'h00 : hour + 5'h01;
                  if (hour == 5'h17) begin
                     day <= (day >= fls_month_days(month, year)) ? 5'h01 : day + 5'h01;
                     if (day >= fls_month_days(month, year)) begin
                        month <= (month == 4'hC) ? 4'h1 : month + 4'h1;
                        if (month == 4'hC)
                           year <= (year == fls_pkg::RTC_YEAR_LAST) ? 7'h00 : year + 7'h01;
                     end
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sqw_cnt <= '0;
         rtc_square_wave <= 1'b0;
      end else if (sqw_cnt == SW'(SQW_HALF_CYC - 1)) begin
         sqw_cnt <= '0;
         rtc_square_wave <= !rtc_square_wave;
      end else begin
         sqw_cnt <= sqw_cnt + 1'b1;
      end
   end

   // low count; the controller extends it with the carry pulses
   logic [7:0] low_count;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_count <= 8'h00;
         overflow_carry_pulse <= 1'b0;
         comparator_sampled <= 1'b0;
         latched_low_count <= 8'h00;
      end else begin
         comparator_sampled <= comp_s;
         overflow_carry_pulse <= 1'b0;
         if (count_src && !src_d) begin
            low_count <= low_count + 8'h01;
            overflow_carry_pulse <= (low_count == 8'hFF);
         end
         if (sync_s && !sync_d) latched_low_count <= low_count;
      end
   end

   // mains period between rising edges; a dead input saturates and falls back to 50 Hz
   logic [LW-1:0] line_cnt;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         line_cnt <= '0;
         select_60hz <= 1'b0;
      end else if (mains_s && !mains_d) begin
         line_cnt <= LW'(1);
         select_60hz <= (line_cnt >= LW'(LINE_MIN_CYC)) && (line_cnt <= LW'(LINE_MAX_CYC));
      end else if (line_cnt > LW'(LINE_MAX_CYC)) begin
         select_60hz <= 1'b0;
      end else begin
         line_cnt <= line_cnt + 1'b1;
      end
   end

   // trim modulator; duty is in clock cycles of the period
   logic [fls_pkg::PWM_W-1:0] pwm_cnt;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pwm_cnt <= '0;
         offset_trim_voltage <= 1'b0;
      end else begin
         pwm_cnt <= (pwm_cnt == fls_pkg::PWM_W'(fls_pkg::PWM_PERIOD_CYC - 1)) ? '0 : pwm_cnt + 1'b1;
         offset_trim_voltage <= pwm_cnt < trim_duty;
      end
   end
endmodule : fls_top
`default_nettype wire

// ### fls_top_monitor.sv
// assertion checker
`timescale 1ns/1ps
`default_nettype none
module fls_top_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic read_n,
   input wire logic write_n,
   input wire logic power_loss_warning,
   input wire logic mem_read_n,
   input wire logic write_high_byte_n,
   input wire logic write_low_byte_n,
   input wire logic backplane_tx,
   input wire logic bp_tx_busy,
   input wire logic panel_tx_busy,
   input wire logic overflow_carry_pulse,
   input wire logic rtc_periodic_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // frame length counter
   logic [11:0] busy_cnt;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_cnt <= 12'h000;
      end else begin
         busy_cnt <= panel_tx_busy ? busy_cnt + 12'h001 : 12'h000;
      end
   end
   AST_WRITE_BLOCKED: assert property (power_loss_warning [*4] |-> write_high_byte_n && write_low_byte_n)
      else $error("write while supply bad");
   AST_READ_FOLLOWS: assert property (mem_read_n == $past(read_n, 3))
      else $error("read strobe wrong");
   AST_LOW_WRITE_CAUSE: assert property (!write_low_byte_n |-> !$past(write_n, 3) && !$past(power_loss_warning, 3))
      else $error("low write without cause");
   AST_CARRY_PULSE: assert property (overflow_carry_pulse |=> !overflow_carry_pulse)
      else $error("carry pulse too long");
   AST_TX_IDLE: assert property (!bp_tx_busy |-> backplane_tx)
      else $error("line low while idle");
   AST_START_BIT: assert property ($rose(bp_tx_busy) |-> !backplane_tx [*8])
      else $error("start bit not low");
   AST_FRAME_LEN: assert property ($fell(panel_tx_busy) |-> busy_cnt == 12'h499)
      else $error("frame length wrong");
   AST_IRQ_PULSE: assert property (rtc_periodic_irq |=> !rtc_periodic_irq)
      else $error("interrupt pulse too long");
endmodule : fls_top_monitor
bind fls_top fls_top_monitor fls_top_monitor_inst (.*);
`default_nettype wire

// ### fls_ctrl_model.sv
// behavioural main controller
`timescale 1ns/1ps
`default_nettype none
module fls_ctrl_model (
   input wire logic clk,
   output logic [15:0] addr_data_bus,
   output logic addr_latch_en,
   output logic inst_fetch
);
   initial {addr_data_bus, addr_latch_en, inst_fetch} = '0;
   // calibration memory lines stay on this side, not modelled
   // latch levels held four clocks
   task automatic latch(input logic [15:0] addr, input logic fetch);
      @(posedge clk);
      #5;
      addr_data_bus = addr;
      inst_fetch = fetch;
      addr_latch_en = 1'b1;
      repeat (4) @(posedge clk);
      #5;
      addr_latch_en = 1'b0;
      repeat (4) @(posedge clk);
      #5;
      addr_data_bus = ~addr;
   endtask : latch
endmodule : fls_ctrl_model
`default_nettype wire

// ### tb.sv
// self-checking bench
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk, reset_n, addr_latch_en, inst_fetch, read_n, write_n, byte_high_enable_n, power_loss_warning;
   logic page_is_ram, rom_select, ram_select, asic_reg_select, mem_read_n, write_high_byte_n, write_low_byte_n;
   logic bp_tx_start, backplane_tx, bp_tx_busy, backplane_rx_n, bp_rx_valid, bp_rx_frame_err;
   logic panel_tx_start, panel_tx, panel_tx_busy, panel_rx, panel_rx_valid, panel_rx_frame_err;
   logic cfg_start, config_shift_clk, config_shift_out, config_shift_in, cfg_busy, cfg_done, rtc_set;
   logic rtc_periodic_irq, rtc_square_wave, freq_mode, comparator_in, frequency_in, count_sync;
   logic comparator_sampled, overflow_carry_pulse, mains_sense, select_60hz, offset_trim_voltage;
   logic [15:0] addr_data_bus, cfg_wr_data, cfg_rd_data;
   logic [19:1] memory_addr_bus;
   logic [8:0] bp_tx_data, bp_rx_data, panel_tx_data, panel_rx_data, got_p, got_b;
   logic [5:0] set_second, set_minute, second, minute;
   logic [4:0] page_sel, set_hour, set_day, hour, day;
   logic [3:0] set_month, month;
   logic [6:0] set_year, year;
   logic [7:0] latched_low_count;
   logic [9:0] trim_duty;
   logic [15:0] map_tab [8] = '{16'h0100, 16'h0101, 16'h1FC0, 16'h1FDF, 16'h2000, 16'h5FFF, 16'h7FFE, 16'h9235};
   logic [31:0] rtc_tab [3] = '{32'hE104_E904, 32'hE103_0983, 32'hFE63_0880};
   int line_tab [5] = '{35, 29, 30, 41, 40};
   int num_errors = 0;
   int comparisons = 0;
   int carries = 0, tot = 0;
   int exp_q [$];
   assign panel_rx = panel_tx;
   assign backplane_rx_n = ~backplane_tx;
   assign config_shift_in = config_shift_out;
   fls_top #(.LINE_MIN_CYC(30), .LINE_MAX_CYC(40), .RTC_TICK_CYC(100), .SQW_HALF_CYC(5)) fls_top_inst (.*);
   fls_ctrl_model fls_ctrl_model_inst (.clk, .addr_data_bus, .addr_latch_en, .inst_fetch);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // pulses caught at every rising edge
   always @(posedge clk) begin
      if (overflow_carry_pulse) carries++;
      if (panel_rx_valid && !panel_rx_frame_err) got_p = panel_rx_data;
      if (bp_rx_valid && !bp_rx_frame_err) got_b = bp_rx_data;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : step
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] ev);
      comparisons++;
      if (seen !== ev) begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, ev, seen);
      end
   endtask : check
   task automatic results();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   function automatic logic [21:0] map_exp(input int a, input int f, input int p, input int r);
      if (a >= 'h8000) return {5'(p), 14'(a >> 1), r == 0, r != 0, 1'b0};
      if (a >= 'h1FC0 && a <= 'h1FDF) return {19'(a >> 1), 3'b001};
      if (a >= 'h2000 && a <= 'h5FFF) return {19'(a >> 1), 3'b100};
      return {19'(a >> 1), f[0], !f[0], 1'b0};
   endfunction : map_exp
   initial begin
      int n;
      {reset_n, read_n, write_n, byte_high_enable_n, power_loss_warning} = 5'b01110;
      {page_is_ram, bp_tx_start, panel_tx_start, cfg_start, rtc_set, freq_mode} = '0;
      {comparator_in, frequency_in, count_sync, mains_sense, page_sel, cfg_wr_data} = '0;
      {bp_tx_data, panel_tx_data, set_second, set_minute, set_hour, set_day, set_month, set_year} = '0;
      void'($urandom(7));
      trim_duty = 10'($urandom_range(fls_pkg::PWM_PERIOD_CYC));
      step(3);
      reset_n = 1'b1;
      step(2);
      foreach (map_tab[i]) begin
         page_sel = 5'($urandom);
         page_is_ram = 1'($urandom);
         fls_ctrl_model_inst.latch(map_tab[i], 1'(i % 2));
         step(6);
         check("map", {memory_addr_bus, rom_select, ram_select, asic_reg_select},
               map_exp(map_tab[i], i % 2, page_sel, page_is_ram));
         {byte_high_enable_n, power_loss_warning, read_n, write_n} = {i[2], i[1], i[0], 1'b0};
         step(4);
         check("strobe", {write_high_byte_n, write_low_byte_n, mem_read_n}, {i[1] | i[2], i[1] | map_tab[i][0], i[0]});
         {read_n, write_n} = 2'b11;
         step(4);
      end
      repeat (2) begin
         {bp_tx_data, panel_tx_data} = 18'($urandom);
         exp_q.push_back(panel_tx_data);
         exp_q.push_back(bp_tx_data);
         {got_p, got_b} = 'x;
         {bp_tx_start, panel_tx_start} = 2'b11;
         step(1);
         {bp_tx_start, panel_tx_start} = 2'b00;
         for (n = 0; n < 11; n++) begin
            step(n == 0 ? 53 : 107);
            check("panel_wire", panel_tx, n == 0 ? 0 : n == 10 ? 1 : panel_tx_data[n - 1]);
         end
         for (n = 0; n < 200 && panel_tx_busy; n++) step(1);
         step(1);
         check("panel_rx", got_p, exp_q.pop_front());
         check("bp_rx", got_b, exp_q.pop_front());
      end
      for (int m = 0; m < 2; m++) begin
         freq_mode = m[0];
         n = 256 + $urandom_range(1, 200);
         // unselected source pulses too
         for (int j = 0; j < n + 5; j++) begin
            comparator_in = m || j < n;
            frequency_in = !m || j < n;
            step(3);
            check("comp", comparator_sampled, comparator_in);
            {comparator_in, frequency_in} = 2'b00;
            step(3);
         end
         tot += n;
         count_sync = 1'b1;
         step(3);
         count_sync = 1'b0;
         step(3);
         check("low_count", latched_low_count, tot % 256);
         check("carries", carries, tot / 256);
      end
      foreach (line_tab[i]) begin
         repeat (5) begin
            mains_sense = 1'b1;
            step(line_tab[i] / 2);
            mains_sense = 1'b0;
            step(line_tab[i] - line_tab[i] / 2);
         end
         check("select_60hz", select_60hz, line_tab[i] >= 30 && line_tab[i] <= 40);
      end
      foreach (rtc_tab[i]) begin
         {set_second, set_minute, set_hour} = {6'h3B, 6'h3B, 5'h17};
         {set_day, set_month, set_year} = rtc_tab[i][31:16];
         rtc_set = 1'b1;
         step(1);
         rtc_set = 1'b0;
         for (n = 0; n < 150 && !rtc_periodic_irq; n++) step(1);
         step(1);
         check("date", {day, month, year, hour, minute, second}, {rtc_tab[i][15:0], 17'h0});
      end
      cfg_wr_data = 16'($urandom);
      cfg_start = 1'b1;
      step(1);
      cfg_start = 1'b0;
      for (n = 0; n < 300 && !cfg_done; n++) step(1);
      check("cfg_loop", cfg_rd_data, cfg_wr_data);
      tot = 0;
      repeat (fls_pkg::PWM_PERIOD_CYC) begin
         step(1);
         tot += offset_trim_voltage;
      end
      check("trim", tot, trim_duty);
      results();
   end
   initial begin
      #(40000 * 50);
      num_errors++;
      results();
   end
endmodule : tb
`default_nettype wire
